/* verilog/pmuprc_pkg.sv */
package pmuprc_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned ACTIVE_WINDOW_S = 8;
    localparam int unsigned ACTIVE_WINDOW_CYC = ACTIVE_WINDOW_S * CLK_HZ;
    localparam int unsigned STEP_TIME_US = 2;
    localparam int unsigned STEP_CYC = STEP_TIME_US * (CLK_HZ / 1_000_000);

    localparam logic [11:0] DEVICE_CONTROL_REG_OFS = 12'h000;
    localparam logic [11:0] OFF_LVL_OFS = 12'h004;
    localparam logic [11:0] INT_STAT_OFS = 12'h008;
    localparam logic [11:0] INT_MASK_OFS = 12'h00C;
    localparam logic [11:0] BOOT_STAT_OFS = 12'h010;
    localparam logic [11:0] SWOFF_STAT_OFS = 12'h014;
    localparam logic [11:0] STATE_OFS = 12'h018;
    localparam logic [11:0] RES_OFS = 12'h020;

    localparam int DEVON_BIT = 0;
    localparam int AUTO_BIT = 1;
    localparam int AUTOUPD_BIT = 2;
    localparam int LVL_HOLD_BIT = 0;
    localparam int LVL_DEVON_BIT = 1;
    localparam int LVL_TIMEOUT_BIT = 2;
    localparam int INT_UP_BIT = 0;
    localparam int INT_OFF_BIT = 1;
    localparam int INT_WARM_BIT = 2;
    localparam int MASK_SLEEP_BIT = 8;
    localparam int RES_MODE_LSB = 8;
    localparam int RES_KEEP_BIT = 10;
    localparam int CAUSE_HW_BIT = 3;

    localparam logic DEVON_RST = 1'b0;
    localparam logic AUTO_RST = 1'b0;
    localparam logic AUTOUPD_RST = 1'b1;
    localparam logic [2:0] OFF_LVL_RST = 3'h0;
    localparam logic [2:0] INT_MASK_RST = 3'h0;
    localparam logic MASK_SLEEP_RST = 1'b1;

    localparam int NUM_RES = 4;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_ON = 2'h1;
    localparam logic [7:0] OTP_VSEL [NUM_RES] = '{8'h40, 8'h50, 8'h60, 8'h70};

    localparam logic [6:0] BANK0_FIRST = 7'h00;
    localparam logic [6:0] BANK0_LAST = 7'h2F;
    localparam logic [6:0] BANK1_FIRST = 7'h30;
    localparam logic [6:0] BANK1_LAST = 7'h5F;

    localparam logic [2:0] CAUSE_NONE = 3'h0;
    localparam logic [2:0] CAUSE_HOLD = 3'h1;
    localparam logic [2:0] CAUSE_DEVON = 3'h2;
    localparam logic [2:0] CAUSE_TIMEOUT = 3'h3;

    typedef enum logic [2:0] {
        ST_OFF, ST_PWRUP, ST_ACTIVE, ST_SLEEP, ST_PWRDN, ST_WARM
    } pmuprc_state_e;

    typedef enum logic [1:0] {
        SEQ_UP, SEQ_ACT_OFF, SEQ_SLP_OFF
    } pmuprc_seq_e;

    typedef struct packed {
        logic last;
        logic [1:0] res;
        logic on;
    } pmuprc_step_s;

    typedef struct packed {
        logic keep;
        logic [1:0] mode;
        logic [7:0] vsel;
    } pmuprc_res_s;

    typedef struct packed {
        logic on_request;
        logic hold_request_pin;
        logic boot;
        logic warm_reset_pin_n;
        logic sleep_request;
    } pmuprc_pins_s;

endpackage : pmuprc_pkg

/* verilog/pmuprc_sync.sv */
module pmuprc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : pmuprc_sync

/* verilog/pmuprc_top.sv */
// Functional notes
// - reset output stays low until the power-up sequence's last step ends
// - hold mode: on request starts power-up, reset output high in ACTIVE
// - hold mode: after 8 s active, shut down unless hold pin is high
// - hold mode: falling hold pin is an off request
// - auto mode: device-on bit set at power-up end, off when cleared
// - no auto set: behave as hold mode but follow the device-on bit
// - boot pin picks config bank 0x00-0x2F or 0x30-0x5F and selector
// - boot level latched at end of off-to-active, readable in status
// - sequencer branches on boot level without altering stored sequence
// - sequences are writes to resource registers; software may rewrite
// - power-on reset clears all; power-on domain is cleared only then
// - off request with hardware level runs active/sleep-to-off sequence
// - hardware reset clears hardware and switch-off domains only
// - hardware domain holds keep bits, interrupt status/mask and modes
// - off request without hardware level clears switch-off domain only
// - switch-off domain holds regulator voltage/mode and device control
// - levels: 0 power-on, 1 hardware, 2 switch-off only
// - interrupt output push-pull active low on any unmasked pending
// - interrupt masked in sleep unless configured; sources maskable
// - warm reset runs off-to-active from ACTIVE or SLEEP, ends ACTIVE
// - warm reset reloads voltage from OTP or keeps it per keep bit
module pmuprc_top
    import pmuprc_pkg::*;
#(
    parameter int unsigned ACTIVE_WINDOW_CYCLES = ACTIVE_WINDOW_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pmuprc_pins_s pins,
    output logic reset_out,
    output logic int_n,
    output logic [6:0] otp_bank_first,
    output logic [6:0] otp_bank_last,
    output logic seq_selector,
    output logic [NUM_RES-1:0] res_enable
);
    localparam pmuprc_pins_s PINS_RST = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    localparam logic [31:0] WIN_LAST = 32'(ACTIVE_WINDOW_CYCLES - 1);
    localparam logic [7:0] STEP_LAST = 8'(STEP_CYC - 1);

    pmuprc_pins_s s;
    pmuprc_state_e state;
    pmuprc_seq_e seq_kind;
    logic [1:0] seq_idx;
    logic [7:0] step_cnt;
    logic [31:0] win_cnt;
    pmuprc_res_s res [NUM_RES];

    logic device_on_bit;
    logic automatic_acknowledge_mode;
    logic auto_update;
    logic [2:0] off_request_level_cfg;
    logic [2:0] int_status;
    logic [2:0] int_mask;
    logic mask_in_sleep;
    logic boot_status;
    logic [3:0] swoff_status;
    logic off_hw_q;
    logic keep_q;
    logic on_q;
    logic warm_q_n;

    pmuprc_sync #(.W($bits(pmuprc_pins_s)), .RST_VAL(PINS_RST)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pins),
        .q(s)
    );

    // fixed sequence table; the boot level only picks a branch
    function automatic pmuprc_step_s seq_step(
        input pmuprc_seq_e kind,
        input logic [1:0] idx,
        input logic boot
    );
        pmuprc_step_s st;
        st = '{1'b0, idx, 1'b0};
        case (kind)
            SEQ_UP: begin
                st.on = 1'b1;
                if (idx == 2'd2) begin
                    st.last = 1'b1;
                    st.res = boot ? 2'd3 : 2'd2;
                end
            end
            SEQ_ACT_OFF: begin
                st.res = 2'd3 - idx;
                st.last = (idx == 2'd3);
            end
            SEQ_SLP_OFF: begin
                st.last = (idx == 2'd3);
            end
            default: st.last = 1'b1;
        endcase
        return st;
    endfunction : seq_step

    function automatic logic is_res(input logic [11:0] a);
        return a[11:4] == RES_OFS[11:4];
    endfunction : is_res

    function automatic logic addr_hit(input logic [11:0] a);
        return is_res(a) || a == DEVICE_CONTROL_REG_OFS || a == OFF_LVL_OFS
            || a == INT_STAT_OFS || a == INT_MASK_OFS
            || a == BOOT_STAT_OFS || a == SWOFF_STAT_OFS
            || a == STATE_OFS;
    endfunction : addr_hit

    pmuprc_step_s step;
    logic running;
    logic step_done;
    logic end_up;
    logic end_off;
    logic in_on;
    logic keep_lvl;
    logic keep_fall;
    logic win_used;
    logic expire;
    logic off_req;
    logic [2:0] cause;
    logic off_hw;
    logic warm_fall;
    logic on_rise;
    logic apb_setup;
    logic apb_wr;
    logic clr_hw;
    logic clr_swo;

    assign step = seq_step(seq_kind, seq_idx, s.boot);
    assign running = state == ST_PWRUP || state == ST_PWRDN
        || state == ST_WARM;
    assign step_done = running && step_cnt == STEP_LAST;
    assign end_up = (state == ST_PWRUP || state == ST_WARM)
        && step_done && step.last;
    assign end_off = state == ST_PWRDN && step_done && step.last;
    assign in_on = state == ST_ACTIVE || state == ST_SLEEP;
    // the acknowledge comes from the pin or from the device-on bit
    assign keep_lvl = automatic_acknowledge_mode ? device_on_bit
        : s.hold_request_pin;
    assign keep_fall = keep_q && !keep_lvl;
    assign win_used = !(automatic_acknowledge_mode && auto_update);
    assign expire = win_used && win_cnt == WIN_LAST;
    assign off_req = in_on && (keep_fall || (expire && !keep_lvl));
    assign warm_fall = warm_q_n && !s.warm_reset_pin_n;
    assign on_rise = s.on_request && !on_q;

    always_comb begin
        if (!keep_fall) begin
            cause = CAUSE_TIMEOUT;
        end else if (automatic_acknowledge_mode) begin
            cause = CAUSE_DEVON;
        end else begin
            cause = CAUSE_HOLD;
        end
    end

    always_comb begin
        case (cause)
            CAUSE_HOLD: off_hw = off_request_level_cfg[LVL_HOLD_BIT];
            CAUSE_DEVON: off_hw = off_request_level_cfg[LVL_DEVON_BIT];
            default: off_hw = off_request_level_cfg[LVL_TIMEOUT_BIT];
        endcase
    end

    // level 1 clears both lower domains, level 2 only the switch-off one
    assign clr_hw = end_off && off_hw_q;
    assign clr_swo = end_off;

    // sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_OFF;
            seq_kind <= SEQ_UP;
            seq_idx <= 2'd0;
            step_cnt <= 8'h00;
        end else begin
            case (state)
                ST_OFF: begin
                    step_cnt <= 8'h00;
                    seq_idx <= 2'd0;
                    if (on_rise) begin
                        state <= ST_PWRUP;
                        seq_kind <= SEQ_UP;
                    end
                end
                ST_PWRUP, ST_WARM, ST_PWRDN: begin
                    step_cnt <= step_done ? 8'h00 : step_cnt + 8'h01;
                    if (step_done && step.last) begin
                        state <= (state == ST_PWRDN) ? ST_OFF : ST_ACTIVE;
                    end else if (step_done) begin
                        seq_idx <= seq_idx + 2'd1;
                    end
                end
                ST_ACTIVE, ST_SLEEP: begin
                    step_cnt <= 8'h00;
                    seq_idx <= 2'd0;
                    if (off_req) begin
                        state <= ST_PWRDN;
                        seq_kind <= (state == ST_SLEEP) ? SEQ_SLP_OFF
                            : SEQ_ACT_OFF;
                    end else if (warm_fall) begin
                        state <= ST_WARM;
                        seq_kind <= SEQ_UP;
                    end else if (state == ST_ACTIVE && s.sleep_request) begin
                        state <= ST_SLEEP;
                    end else if (state == ST_SLEEP && !s.sleep_request) begin
                        state <= ST_ACTIVE;
                    end
                end
                default: state <= ST_OFF;
            endcase
        end
    end

    // edge history for the on and warm-reset inputs and the acknowledge level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keep_q <= 1'b0;
            on_q <= 1'b0;
            warm_q_n <= 1'b1;
        end else begin
            keep_q <= in_on && keep_lvl;
            on_q <= s.on_request;
            warm_q_n <= s.warm_reset_pin_n;
        end
    end

    // active window, restarted by each power-up, held one count past WIN_LAST
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt <= 32'h0000_0000;
        end else if (state == ST_PWRUP) begin
            win_cnt <= 32'h0000_0000;
        end else if (in_on && win_cnt != WIN_LAST + 32'h1) begin
            win_cnt <= win_cnt + 32'h0000_0001;
        end
    end

    // power-on domain: only presetn clears these
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_request_level_cfg <= OFF_LVL_RST;
            swoff_status <= {1'b0, CAUSE_NONE};
            boot_status <= 1'b0;
            off_hw_q <= 1'b0;
        end else begin
            if (apb_wr && paddr == OFF_LVL_OFS) begin
                off_request_level_cfg <= pwdata[2:0];
            end
            if (off_req) begin
                off_hw_q <= off_hw;
                swoff_status <= {off_hw, cause};
            end
            if (end_up) begin
                boot_status <= s.boot;
            end
        end
    end

    // hardware domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            automatic_acknowledge_mode <= AUTO_RST;
            auto_update <= AUTOUPD_RST;
            int_mask <= INT_MASK_RST;
            mask_in_sleep <= MASK_SLEEP_RST;
            int_status <= 3'h0;
        end else begin
            if (clr_hw) begin
                automatic_acknowledge_mode <= AUTO_RST;
                auto_update <= AUTOUPD_RST;
                int_mask <= INT_MASK_RST;
                mask_in_sleep <= MASK_SLEEP_RST;
            end else if (apb_wr && paddr == INT_MASK_OFS) begin
                int_mask <= pwdata[2:0];
                mask_in_sleep <= pwdata[MASK_SLEEP_BIT];
            end else if (apb_wr && paddr == DEVICE_CONTROL_REG_OFS
                         && state == ST_OFF) begin
                automatic_acknowledge_mode <= pwdata[AUTO_BIT];
                auto_update <= pwdata[AUTOUPD_BIT];
            end
            // clear first, then new events, so a set is never lost
            int_status <= (clr_hw ? 3'h0
                : (apb_wr && paddr == INT_STAT_OFS)
                ? int_status & ~pwdata[2:0] : int_status)
                | {end_up && state == ST_WARM, end_off,
                   end_up && state == ST_PWRUP};
        end
    end

    // switch-off domain: device control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_on_bit <= DEVON_RST;
        end else if (clr_swo) begin
            device_on_bit <= DEVON_RST;
        end else if (end_up && automatic_acknowledge_mode && auto_update) begin
            device_on_bit <= 1'b1;
        end else if (apb_wr && paddr == DEVICE_CONTROL_REG_OFS) begin
            device_on_bit <= pwdata[DEVON_BIT];
        end
    end

    // resource registers: sequencer writes, software may overwrite
    for (genvar i = 0; i < NUM_RES; i++) begin : g_res
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                res[i] <= '{1'b0, MODE_OFF, OTP_VSEL[i]};
            end else begin
                if (clr_hw) begin
                    res[i].keep <= 1'b0;
                end else if (apb_wr && is_res(paddr)
                             && paddr[3:2] == 2'(i)) begin
                    res[i].keep <= pwdata[RES_KEEP_BIT];
                end
                if (clr_swo) begin
                    res[i].mode <= MODE_OFF;
                    res[i].vsel <= OTP_VSEL[i];
                end else if (step_done && step.res == 2'(i)) begin
                    res[i].mode <= step.on ? MODE_ON : MODE_OFF;
                    if (step.on && !(state == ST_WARM && res[i].keep)) begin
                        res[i].vsel <= OTP_VSEL[i];
                    end
                end else if (apb_wr && is_res(paddr)
                             && paddr[3:2] == 2'(i)) begin
                    res[i].mode <= pwdata[RES_MODE_LSB +: 2];
                    res[i].vsel <= pwdata[7:0];
                end
            end
        end
    end

    // apb slave: no wait state, answer registered at the setup edge
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pready && pwrite && !pslverr;

    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        if (is_res(paddr)) begin
            rd_val[10:0] = res[paddr[3:2]];
        end else begin
            case (paddr)
                DEVICE_CONTROL_REG_OFS: begin
                    rd_val[DEVON_BIT] = device_on_bit;
                    rd_val[AUTO_BIT] = automatic_acknowledge_mode;
                    rd_val[AUTOUPD_BIT] = auto_update;
                end
                OFF_LVL_OFS: rd_val[2:0] = off_request_level_cfg;
                INT_STAT_OFS: rd_val[2:0] = int_status;
                INT_MASK_OFS: begin
                    rd_val[2:0] = int_mask;
                    rd_val[MASK_SLEEP_BIT] = mask_in_sleep;
                end
                BOOT_STAT_OFS: rd_val[0] = boot_status;
                SWOFF_STAT_OFS: rd_val[3:0] = swoff_status;
                STATE_OFS: rd_val[2:0] = state;
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && !addr_hit(paddr);
            // refused accesses of either direction answer with zero data
            if (apb_setup && (!pwrite || !addr_hit(paddr))) begin
                prdata <= rd_val;
            end
        end
    end

    // pin outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_out <= 1'b0;
            int_n <= 1'b1;
            otp_bank_first <= BANK0_FIRST;
            otp_bank_last <= BANK0_LAST;
            seq_selector <= 1'b0;
            res_enable <= '0;
        end else begin
            reset_out <= in_on;
            int_n <= !((|(int_status & ~int_mask))
                && !(state == ST_SLEEP && mask_in_sleep));
            otp_bank_first <= s.boot ? BANK1_FIRST : BANK0_FIRST;
            otp_bank_last <= s.boot ? BANK1_LAST : BANK0_LAST;
            seq_selector <= s.boot;
            for (int i = 0; i < NUM_RES; i++) begin
                res_enable[i] <= res[i].mode != MODE_OFF;
            end
        end
    end
endmodule : pmuprc_top

/* tb/pmuprc_assertions.sv */
module pmuprc_assertions
    import pmuprc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire pmuprc_pins_s pins,
    input wire logic reset_out,
    input wire logic [6:0] otp_bank_first,
    input wire logic [6:0] otp_bank_last,
    input wire logic seq_selector,
    input wire logic [NUM_RES-1:0] res_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_bank_high: assert property (seq_selector |->
        otp_bank_first == 7'h30 && otp_bank_last == 7'h5F)
        else $error("bank wrong for selector one");
    chk_bank_low: assert property (!seq_selector |->
        otp_bank_first == 7'h00 && otp_bank_last == 7'h2F)
        else $error("bank wrong for selector zero");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_ready_answer: assert property (psel && !penable |=> pready)
        else $error("no answer in access cycle");
    chk_error_data: assert property (pslverr |-> pready && prdata == '0)
        else $error("error response malformed");
    chk_reset_wait: assert property ($rose(pins.on_request) && !reset_out
        |=> !reset_out [*8])
        else $error("reset released before sequence end");
    chk_reset_cause: assert property ($rose(reset_out) |-> res_enable != '0)
        else $error("reset released with no resource on");
    chk_off_drain: assert property ($fell(reset_out) &&
        pins.warm_reset_pin_n |-> ##[1:100] res_enable == '0)
        else $error("off sequence left resources on");
    cover property ($rose(reset_out));
    cover property ($fell(reset_out));
    cover property (pslverr);
endmodule : pmuprc_assertions

/* tb/pmuprc_host.sv */
module pmuprc_host (
    input wire logic pclk,
    input wire logic reset_out,
    input wire logic keep,
    input wire logic [7:0] dly,
    output logic hold_request_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt = 8'h00;
    initial hold_request_pin = 1'b0;
    // raise the hold pin some cycles after release, keep it while wanted
    always @(posedge pclk) begin
        if (!keep) begin
            hold_request_pin <= 1'b0;
            cnt <= 8'h00;
        end else if (reset_out && cnt != dly) begin
            cnt <= cnt + 8'h01;
        end else if (reset_out) begin
            hold_request_pin <= 1'b1;
        end
    end
endmodule : pmuprc_host

/* tb/pmuprc_top_tb_top.sv */
module pmuprc_top_tb_top;
    import pmuprc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WIN = 200;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, keep = 1'b0, er, hold;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, reset_out, int_n, seq_selector;
    logic on_r = 1'b0, boot_r = 1'b0, warm_n = 1'b1, slp = 1'b0;
    logic [6:0] otp_bank_first, otp_bank_last;
    logic [3:0] res_enable;
    logic [7:0] dly = 8'h05;
    logic [31:0] m [int];
    pmuprc_pins_s pins;
    int fail_count = 0, checked = 0;
    assign pins = '{on_r, hold, boot_r, warm_n, slp};
    always #50 pclk = ~pclk;
    pmuprc_top #(.ACTIVE_WINDOW_CYCLES(WIN)) pmuprc_top_i (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pins, .reset_out, .int_n, .otp_bank_first,
        .otp_bank_last, .seq_selector, .res_enable);
    pmuprc_host pmuprc_host_i (.pclk, .reset_out, .keep, .dly,
        .hold_request_pin(hold));
    task stop_test();
        if (fail_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a == INT_STAT_OFS) m[a] = m[a] & ~d;
        else m[a] = d;
    endtask : wr
    task cmp_all();
        logic [3:0] en;
        foreach (m[k]) begin
            apb(1'b0, 12'(k), 32'h0);
            chk("reg", rd, m[k]);
        end
        for (int i = 0; i < NUM_RES; i++)
            en[i] = m[RES_OFS + 4 * i][9:8] != 2'h0;
        chk("res_en", {28'h0, res_enable}, {28'h0, en});
        chk("sel", {31'h0, seq_selector}, {31'h0, boot_r});
        if (m[STATE_OFS] != 32'h3)
            chk("int_n", {31'h0, int_n},
                {31'h0, ~|(m[INT_STAT_OFS][2:0] & ~m[INT_MASK_OFS][2:0])});
    endtask : cmp_all
    task wait_v(input logic v, input int n);
        for (int i = 0; i < n && reset_out !== v; i++) @(posedge pclk);
        chk("reset_out", {31'h0, reset_out}, {31'h0, v});
    endtask : wait_v
    task seq_up(input logic b, input logic w);
        int a;
        m[STATE_OFS] = 32'h2;
        m[BOOT_STAT_OFS] = {31'h0, b};
        m[INT_STAT_OFS] |= w ? 32'h4 : 32'h1;
        if (m[DEVICE_CONTROL_REG_OFS][2:1] == 2'h3) m[DEVICE_CONTROL_REG_OFS] |= 32'h1;
        for (int i = 0; i < NUM_RES; i++) begin
            a = RES_OFS + 4 * i;
            if (i < 2 || i == (b ? 3 : 2))
                m[a] = (m[a] & 32'h400) | 32'h100 |
                    (w && m[a][10] ? m[a] & 32'hFF : 32'(OTP_VSEL[i]));
        end
    endtask : seq_up
    task seq_off(input logic [2:0] c, input logic hw);
        int a;
        cyc(100);
        m[STATE_OFS] = 32'h0;
        m[SWOFF_STAT_OFS] = {28'h0, hw, c};
        m[DEVICE_CONTROL_REG_OFS][0] = 1'b0;
        for (int i = 0; i < NUM_RES; i++) begin
            a = RES_OFS + 4 * i;
            m[a] = (hw ? 32'h0 : m[a] & 32'h400) | 32'(OTP_VSEL[i]);
        end
        if (hw) begin
            m[DEVICE_CONTROL_REG_OFS] = 32'h4;
            m[INT_MASK_OFS] = 32'h100;
            m[INT_STAT_OFS] = 32'h2;
        end else m[INT_STAT_OFS] |= 32'h2;
        cmp_all();
    endtask : seq_off
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    task power_on(input logic b);
        boot_r <= b;
        cyc(4);
        on_r <= 1'b1;
        wait_v(1'b1, 200);
        on_r <= 1'b0;
        seq_up(b, 1'b0);
    endtask : power_on
    initial begin
        #2000000;
        fail_count++;
        stop_test();
    end
    initial begin
        void'($urandom(69808));
        m = '{DEVICE_CONTROL_REG_OFS: 32'h4, INT_MASK_OFS: 32'h100, OFF_LVL_OFS: 0,
            INT_STAT_OFS: 0, BOOT_STAT_OFS: 0, SWOFF_STAT_OFS: 0,
            STATE_OFS: 0};
        for (int i = 0; i < NUM_RES; i++)
            m[RES_OFS + 4 * i] = 32'(OTP_VSEL[i]);
        cyc(2);
        presetn <= 1'b1;
        cmp_all();
        apb(1'b0, 12'h01C, 32'h0);
        chk("slverr", {31'h0, er}, 32'h1);
        // hold mode, boot high, hardware level on hold fall, off from sleep
        wr(OFF_LVL_OFS, 32'h1);
        dly <= 8'($urandom_range(2, 150));
        keep <= 1'b1;
        power_on(1'b1);
        cyc(WIN + 100);
        cmp_all();
        slp <= 1'b1;
        cyc(40);
        m[STATE_OFS] = 32'h3;
        chk("int_n", {31'h0, int_n}, 32'h1);
        wr(INT_MASK_OFS, 32'h0);
        cyc(3);
        chk("int_n", {31'h0, int_n}, 32'h0);
        keep <= 1'b0;
        wait_v(1'b0, 20);
        slp <= 1'b0;
        seq_off(3'h1, 1'b1);
        // hold mode, boot low, host never holds: window runs out
        wr(INT_MASK_OFS, 32'h104);
        power_on(1'b0);
        cyc(WIN - 10);
        chk("reset_out", {31'h0, reset_out}, 32'h1);
        wait_v(1'b0, 30);
        seq_off(3'h3, 1'b0);
        // automatic acknowledge, warm reset, then device-on cleared
        wr(DEVICE_CONTROL_REG_OFS, 32'h6);
        power_on(1'b0);
        cyc(WIN + 50);
        cmp_all();
        wr(RES_OFS, {21'h0, 3'h5, 8'($urandom)});
        wr(RES_OFS + 12'h004, {21'h0, 3'h1, 8'($urandom)});
        warm_n <= 1'b0;
        cyc(10);
        warm_n <= 1'b1;
        cyc(10);
        wait_v(1'b1, 200);
        seq_up(1'b0, 1'b1);
        cmp_all();
        wr(INT_STAT_OFS, 32'h5);
        wr(DEVICE_CONTROL_REG_OFS, 32'h6);
        wait_v(1'b0, 20);
        seq_off(3'h2, 1'b0);
        // device-on without automatic set: host sets and keeps the bit
        wr(DEVICE_CONTROL_REG_OFS, 32'h2);
        power_on(1'b1);
        wr(DEVICE_CONTROL_REG_OFS, 32'h3);
        cyc(WIN + 50);
        cmp_all();
        wr(DEVICE_CONTROL_REG_OFS, 32'h2);
        wait_v(1'b0, 20);
        seq_off(3'h2, 1'b0);
        stop_test();
    end
endmodule : pmuprc_top_tb_top
bind pmuprc_top pmuprc_assertions pmuprc_assertions_i (.pclk, .presetn,
    .psel, .penable, .prdata, .pready, .pslverr, .pins, .reset_out,
    .otp_bank_first, .otp_bank_last, .seq_selector, .res_enable);
